// *** src/boost_pump_params.svh ***
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by bare name from the design module
`ifndef BOOST_PUMP_PARAMS_SVH
`define BOOST_PUMP_PARAMS_SVH
`define PUMP_ENABLE_ADDR 8'h5f
`define PUMP_SELECT_ADDR 8'h61
`define BOOST_ENABLE_ADDR 8'h62
`define BOOST_CONFIG_ADDR 8'h63
`define BOOST_PEAK_ADDR 8'h64
`define SEQ_SW_CTRL 3'h7
`define SEQ_AT_0PCT 3'h2
`define SEQ_AT_25PCT 3'h3
`define SEQ_AT_50PCT 3'h4
`define SEL_OFF 2'h0
`define SEL_ON 2'h1
`define SEL_INPUTS 2'h2
`define BOOST_ENABLE_MASK 8'h03
`define BOOST_CONFIG_MASK 8'h0f
`define BOOST_PEAK_MASK 8'h8f
`define PUMP_ENABLE_MASK 8'h03
`define FAST_START_MS 50
`define SLOW_START_MS 100
`define PRECHARGE_CODE 4'h0
`define PHASE_AT_0PCT 3'h1
`define PHASE_AT_25PCT 3'h2
`define PHASE_AT_50PCT 3'h3
`define PHASE_FULL 3'h4
`define SEL_MSB 1
`define CONFIG_MSB 3
`define PEAK_CODE_MSB 3
`define BYPASS_BIT 7
`define DISCHARGE_BIT 3
`define ADAPTIVE_BIT 2
`define FAST_START_BIT 1
`define SWITCH_HALF_BIT 0
`define REG_RESET_VALUE 8'h00
`endif

// *** src/boost_pump_pkg.sv ***
// Types shared by the enable and configuration logic
// Assumes the parameter header is on the include path
package boost_pump_pkg;
  typedef struct packed {
    logic [1:0] pumpEnableSel;
    logic [7:0] pumpInputSelect;
    logic [1:0] boostEnableSel;
    logic [3:0] boostConfig;
    logic [7:0] boostPeak;
    logic [7:0] readData;
    logic pumpOn;
    logic boostOn;
    logic dischargeReq;
    logic adaptivePeak;
    logic fastStartup;
    logic switchHalving;
    logic tableBypass;
    logic [3:0] peakCode;
  } state_type;
  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_access_type;
endpackage

// *** src/boost_pump_enable_ctrl.sv ***
// Enable and configuration registers of the charge pump and boost stages
// Assumes a serial port front end giving one-cycle read and write strobes
`timescale 1ns/1ps
`default_nettype none
`include "boost_pump_params.svh"
module boost_pump_enable_ctrl #(
  parameter int NUM_INPUTS = 8,
  parameter int NUM_PUMP_INPUTS = 6
) (
  input wire logic clk, // 50 MHz clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire boost_pump_pkg::reg_access_type regAccess, // Register strobe, address, data
  input wire logic [2:0] pumpSequenceCfg, // Factory pump sequence code
  input wire logic [2:0] boostSequenceCfg, // Factory boost sequence code
  input wire logic [2:0] sequencePhase, // 0 none,1 at 0%,2 at 25%,3 at 50%,4 at 100%
  input wire logic [NUM_INPUTS-1:0] multipurposeCtrlInput, // Control inputs
  input wire logic [3:0] tablePeakCode, // Peak code from lookup table
  output logic [7:0] readData, // Read data, valid cycle after read
  output logic pumpOn, // Charge pump enable
  output logic boostOn, // Boost enable
  output logic boostDischarge, // Boost passive discharge request
  output logic adaptivePeak, // Adaptive peak current on
  output logic fastStartup, // 50ms startup selected
  output logic switchHalving, // Half boost switch size
  output logic tableBypass, // Peak code from register
  output logic [3:0] peakCode // Effective boost peak code
);
  import boost_pump_pkg::*;

  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  // Read mux and input OR are sized for eight control inputs
  if (NUM_INPUTS != 8) begin : g_bad_input_count
    $error("Control input count must be 8");
  end

  if (NUM_PUMP_INPUTS < 1 || NUM_PUMP_INPUTS > NUM_INPUTS) begin : g_bad_pump_count
    $error("Pump input count must lie between 1 and the control input count");
  end

  // ----------------------------------------
  // Constants and state
  // ----------------------------------------
  // Select bits above the pump input count are stored but never gate the OR
  localparam logic [7:0] PUMP_MASK = 8'((9'h001 << NUM_PUMP_INPUTS) - 9'h001);

  state_type cur, next_cur;

  // ----------------------------------------
  // Sequence decode
  // ----------------------------------------
  // Fixed codes switch the stage on once the power-up delay passes their point
  function automatic logic fixedSeqOn(input logic [2:0] seq, input logic [2:0] phase);
    logic result;
    result = 1'b0;
    case (seq)
      `SEQ_AT_0PCT: result = (phase >= `PHASE_AT_0PCT);
      `SEQ_AT_25PCT: result = (phase >= `PHASE_AT_25PCT);
      `SEQ_AT_50PCT: result = (phase >= `PHASE_AT_50PCT);
      default: result = 1'b0;
    endcase
    return result;
  endfunction

  // Reserved select code keeps the stage off
  function automatic logic softSelOn(input logic [1:0] sel, input logic anyInput);
    logic result;
    result = 1'b0;
    case (sel)
      `SEL_OFF: result = 1'b0;
      `SEL_ON: result = 1'b1;
      `SEL_INPUTS: result = anyInput;
      default: result = 1'b0;
    endcase
    return result;
  endfunction

  // Software select only counts after the full power-up delay
  function automatic logic seqEnable(input logic [2:0] seq, input logic [2:0] phase,
                                     input logic [1:0] sel, input logic anyInput);
    logic result;
    result = 1'b0;
    if (seq == `SEQ_SW_CTRL) begin
      result = (phase >= `PHASE_FULL) && softSelOn(sel, anyInput);
    end else begin
      result = fixedSeqOn(seq, phase);
    end
    return result;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic pumpAnyInput;
    logic [7:0] readWord;
    pumpAnyInput = 1'b0;
    readWord = `REG_RESET_VALUE;
    next_cur = cur;

    // Unmapped addresses leave every field alone
    // masked boost writes
    if (regAccess.write) begin
      case (regAccess.addr)
        `PUMP_ENABLE_ADDR: begin
          next_cur.pumpEnableSel = regAccess.data[`SEL_MSB:0];
        end
        `PUMP_SELECT_ADDR: begin
          next_cur.pumpInputSelect = regAccess.data;
        end
        `BOOST_ENABLE_ADDR: begin
          next_cur.boostEnableSel = regAccess.data[`SEL_MSB:0];
        end
        `BOOST_CONFIG_ADDR: begin
          next_cur.boostConfig = regAccess.data[`CONFIG_MSB:0];
        end
        `BOOST_PEAK_ADDR: begin
          next_cur.boostPeak = regAccess.data & `BOOST_PEAK_MASK;
        end
        default: begin
          next_cur = cur;
        end
      endcase
    end

    // Read returns the value held before a same-cycle write
    // sequence read only
    if (regAccess.read) begin
      case (regAccess.addr)
        `PUMP_ENABLE_ADDR: begin
          readWord = {pumpSequenceCfg, 3'h0, cur.pumpEnableSel};
        end
        `PUMP_SELECT_ADDR: begin
          readWord = cur.pumpInputSelect;
        end
        `BOOST_ENABLE_ADDR: begin
          readWord = {boostSequenceCfg, 3'h0, cur.boostEnableSel};
        end
        `BOOST_CONFIG_ADDR: begin
          readWord = {4'h0, cur.boostConfig};
        end
        `BOOST_PEAK_ADDR: begin
          readWord = cur.boostPeak;
        end
        default: begin
          readWord = `REG_RESET_VALUE;
        end
      endcase
    end
    next_cur.readData = readWord;

    // ----------------------------------------
    // Charge pump enable
    // ----------------------------------------
    // select bits gate
    pumpAnyInput = |(multipurposeCtrlInput & cur.pumpInputSelect & PUMP_MASK);
    next_cur.pumpOn = seqEnable(pumpSequenceCfg, sequencePhase, cur.pumpEnableSel,
                                pumpAnyInput);

    // ----------------------------------------
    // Boost enable and discharge
    // ----------------------------------------
    // boost sequencing
    // boost enable decode
    // Input control of the boost needs a select register this block lacks
    next_cur.boostOn = seqEnable(boostSequenceCfg, sequencePhase, cur.boostEnableSel, 1'b0);
    // discharge when disabled
    // Off and hard-reset discharge is handled outside this block
    next_cur.dischargeReq = cur.boostConfig[`DISCHARGE_BIT]
                            && boostSequenceCfg == `SEQ_SW_CTRL
                            && cur.boostEnableSel == `SEL_OFF;

    // ----------------------------------------
    // Boost configuration
    // ----------------------------------------
    // adaptive peak
    next_cur.adaptivePeak = cur.boostConfig[`ADAPTIVE_BIT];
    next_cur.fastStartup = cur.boostConfig[`FAST_START_BIT];
    next_cur.switchHalving = cur.boostConfig[`SWITCH_HALF_BIT];
    next_cur.tableBypass = cur.boostPeak[`BYPASS_BIT];
    if (cur.boostPeak[`BYPASS_BIT]) begin
      next_cur.peakCode = cur.boostPeak[`PEAK_CODE_MSB:0];
    end else begin
      next_cur.peakCode = tablePeakCode;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Every output is a field of the state register
  assign readData = cur.readData;
  assign pumpOn = cur.pumpOn;
  assign boostOn = cur.boostOn;
  assign boostDischarge = cur.dischargeReq;
  assign adaptivePeak = cur.adaptivePeak;
  assign fastStartup = cur.fastStartup;
  assign switchHalving = cur.switchHalving;
  assign tableBypass = cur.tableBypass;
  assign peakCode = cur.peakCode;
endmodule
`default_nettype wire

// *** sim/boost_pump_enable_ctrl_assertions.sv ***
// Port checks of the boost and pump enable block
// Assumes binding into every instance of the block
`timescale 1ns/1ps
`default_nettype none
module boost_pump_enable_ctrl_assertions (
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire boost_pump_pkg::reg_access_type regAccess, // access
  input wire logic [2:0] boostSequenceCfg, // boost seq
  input wire logic [2:0] sequencePhase, // phase
  input wire logic [3:0] tablePeakCode, // table code
  input wire logic [7:0] readData, // read data
  input wire logic boostOn, // boost on
  input wire logic boostDischarge, // discharge
  input wire logic tableBypass, // bypass
  input wire logic [3:0] peakCode // peak code
);
  import boost_pump_pkg::*;
  // ----
  // Checks
  // ----
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  seq_off_a: assert property (boostSequenceCfg == 3'h0 |=> !boostOn)
    else $error("boost on with sequence off");
  seq_half_a: assert property (
    boostSequenceCfg == 3'h4 && sequencePhase > 3'h2 |=> boostOn)
    else $error("boost off after half delay");
  ena_read_a: assert property (regAccess.read && regAccess.addr == 8'h62 |=>
    readData[7:5] == $past(boostSequenceCfg) && readData[4:2] == 3'h0)
    else $error("enable register read wrong");
  cfg_read_a: assert property (regAccess.read && regAccess.addr == 8'h63 |=>
    readData[7:4] == 4'h0)
    else $error("config unused bits set");
  peak_read_a: assert property (regAccess.read && regAccess.addr == 8'h64 |=>
    readData[6:4] == 3'h0)
    else $error("peak unused bits set");
  unmapped_read_a: assert property (regAccess.read && regAccess.addr > 8'h64 |=>
    readData == 8'h00)
    else $error("unmapped read not zero");
  table_code_a: assert property ($past(rst_n) && !tableBypass |->
    peakCode == $past(tablePeakCode))
    else $error("table code not passed");
  discharge_a: assert property (boostDischarge |->
    !boostOn && $past(boostSequenceCfg) == 3'h7)
    else $error("discharge while boost on");
endmodule
bind boost_pump_enable_ctrl boost_pump_enable_ctrl_assertions u_chk (.*);
`default_nettype wire

// *** sim/boost_pump_enable_ctrl_tb.sv ***
// Bench driving register accesses and control inputs of the block
// Assumes the checker is bound from its own file
`timescale 1ns/1ps
`default_nettype none
module boost_pump_enable_ctrl_tb;
  import boost_pump_pkg::*;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  reg_access_type regAccess = '0;
  logic [2:0] pumpSequenceCfg = 3'h0, boostSequenceCfg = 3'h0, sequencePhase = 3'h4;
  logic [7:0] multipurposeCtrlInput = 8'h00, readData;
  logic [3:0] tablePeakCode = 4'ha, peakCode;
  logic pumpOn, boostOn, boostDischarge, adaptivePeak, fastStartup, switchHalving, tableBypass;
  int err_total = 0;
  int cmp_count = 0;
  boost_pump_enable_ctrl u_boost_pump_enable_ctrl (.*);
  initial forever #10 clk = ~clk;
  // ----
  // Access tasks
  // ----
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wt();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk) regAccess <= '{1'b1, 1'b0, a, d};
    @(posedge clk) regAccess.write <= 1'b0;
    wt();
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk) regAccess <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk) regAccess.read <= 1'b0;
    #1 chk("readData", readData, e);
  endtask
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h62, 8'h00);
    rd(8'h63, 8'h00);
    rd(8'h64, 8'h00);
    rd(8'h70, 8'h00);
    $display("reset reads done");
    for (int i = 1; i >= 0; i--) begin
      wr(8'h63, {8{i[0]}});
      rd(8'h63, {4'h0, {4{i[0]}}});
      chk("adaptivePeak", adaptivePeak, i[0]);
      chk("fastStartup", fastStartup, i[0]);
      chk("switchHalving", switchHalving, i[0]);
    end
    wr(8'h64, 8'hff);
    rd(8'h64, 8'h8f);
    chk("peakCode", peakCode, 4'hf);
    chk("tableBypass", tableBypass, 1'b1);
    wr(8'h64, 8'h05);
    chk("tableBypass", tableBypass, 1'b0);
    chk("peakCode", peakCode, tablePeakCode);
    $display("config and peak done");
    @(posedge clk) boostSequenceCfg <= 3'h7;
    wr(8'h63, 8'h08);
    for (int i = 0; i < 4; i++) begin
      wr(8'h62, i == 3 ? 8'hff : 8'(i));
      chk("boostOn", boostOn, i == 1);
      chk("boostDischarge", boostDischarge, i == 0);
    end
    rd(8'h62, 8'he3);
    wr(8'h62, 8'h01);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) boostSequenceCfg <= (i == 3) ? 3'h7 : 3'(i + 2);
      sequencePhase <= 3'(i);
      wt();
      chk("boostOn", boostOn, 1'b0);
      @(posedge clk) sequencePhase <= 3'(i + 1);
      wt();
      chk("boostOn", boostOn, 1'b1);
    end
    $display("boost enable done");
    @(posedge clk) pumpSequenceCfg <= 3'h7;
    wr(8'h5f, 8'h02);
    for (int b = 0; b < 7; b++) begin
      @(posedge clk) multipurposeCtrlInput <= 8'h01 << b;
      wr(8'h61, 8'h01 << b);
      chk("pumpOn", pumpOn, b < 6);
      wr(8'h61, ~(8'h01 << b));
      chk("pumpOn", pumpOn, 1'b0);
    end
    for (int i = 0; i < 3; i++) begin
      wr(8'h5f, i == 2 ? 8'h03 : 8'(1 - i));
      chk("pumpOn", pumpOn, i == 0);
    end
    rd(8'h5f, 8'he3);
    rd(8'h61, 8'hbf);
    @(posedge clk) multipurposeCtrlInput <= 8'h3f;
    wr(8'h5f, 8'h02);
    chk("pumpOn", pumpOn, 1'b1);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) pumpSequenceCfg <= 3'(4 * i);
      sequencePhase <= 3'(2 + i);
      wt();
      chk("pumpOn", pumpOn, i == 1);
    end
    $display("pump enable done");
    @(posedge clk) rst_n <= 1'b0;
    @(posedge clk) rst_n <= 1'b1;
    #1 chk("pumpOn", pumpOn, 1'b0);
    rd(8'h61, 8'h00);
    rd(8'h63, 8'h00);
    chk("pumpOn", pumpOn, 1'b1);
    $display("mid-run reset done");
    end_sim();
  end
endmodule
`default_nettype wire
